// *** src/dma_counter_and_config.sv ***
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Writable 32-bit total byte counter
// - Counter counts down, reads bytes left
// - IN FIFO 8 bytes, drained one byte per cycle, 80ns at a 10ns clock
// - OUT buffer released only after FIFO empties
// - Disabled counter still decrements and wraps
// - Counter bytes ordered MSB 31:24, LSB 7:0
// - Bit 13 selects non-ATA or ATA core
// - Bits 12:11 master timing, code 11 custom
// - Bits 10:8 PIO timing, high codes reserved
// - Bit 7 disables counter, slave mode only
// - Map 00 uses read/write strobes
// - Map 01 mixes read strobe and acknowledge
// - Map 10 acknowledge latches and drives
// - Map bits 3:2 handshake only, 11 reserved
// - Bit 0 selects 8 or 16-bit bus
// - No request before configuration written
// - Master-select bit picks slave or master
// - PIO transfers are always 16-bit
module dma_counter_and_config
    import dma_cc_pkg::*;
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_b,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // Transfer control from the command logic
    input wire logic i_master_dma,
    input wire logic i_xfer_start,
    input wire logic i_xfer_stop,
    input wire logic i_dir_in,
    input wire logic i_pio,
    // DMA bus pins
    input wire logic i_dma_read_strobe,
    input wire logic i_dma_write_strobe,
    input wire logic i_dma_acknowledge,
    input wire logic [15:0] i_dma_data,
    output logic [15:0] o_dma_data,
    output logic o_dma_data_oe,
    output logic o_dma_request,
    // Endpoint buffer, IN direction
    output logic [7:0] o_ep_wr_data,
    output logic o_ep_wr_valid,
    input wire logic i_ep_wr_ready,
    // Endpoint buffer, OUT direction
    input wire logic [7:0] i_ep_rd_data,
    input wire logic i_ep_rd_valid,
    output logic o_ep_rd_ready,
    output logic o_ep_release,
    // Decoded configuration
    output logic o_core_mode_select,
    output logic [1:0] o_master_timing,
    output logic o_strobe_timing_en,
    output logic [2:0] o_pio_timing_select,
    output logic o_bus_16
);
    typedef struct packed {
        logic [31:0] count;
        logic core;
        logic [1:0] tim;
        logic [2:0] pio;
        logic dis;
        logic [1:0] map;
        logic w16;
        logic cfg_seen;
        logic active;
        logic dir_in;
        logic pend_rel;
        logic rel;
        logic [7:0][7:0] fifo;
        logic [2:0] wp;
        logic [2:0] rp;
        logic [3:0] fcnt;
        logic lat_q;
        logic drv_q;
        logic [15:0] dout;
        logic [7:0] ep_data;
        logic ep_vld;
        logic [31:0] rdata;
    } state_t;

    state_t st_r;
    state_t st_nxt;
    logic rst_s1_r;
    logic rst_sync_b;
    logic rd_lvl;
    logic wr_lvl;
    logic ack_lvl;
    logic lat_lvl;
    logic drv_lvl;
    logic cnt_en;
    logic two;
    logic [3:0] step;
    logic [3:0] room;
    logic lat_edge;
    logic drv_edge;

    // Reset release through two flops
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_s1_r <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_sync_b <= rst_s1_r;
        end
    end

    pin_sync u_sync_rd (.i_mclk(i_mclk), .i_rst_b(rst_sync_b), .i_pin(i_dma_read_strobe), .o_level(rd_lvl));
    pin_sync u_sync_wr (.i_mclk(i_mclk), .i_rst_b(rst_sync_b), .i_pin(i_dma_write_strobe), .o_level(wr_lvl));
    pin_sync u_sync_ack (.i_mclk(i_mclk), .i_rst_b(rst_sync_b), .i_pin(i_dma_acknowledge), .o_level(ack_lvl));

    // Strobe mapping; reserved code 11 selects nothing
    always_comb begin
        case (st_r.map)
            MAP_RW: begin
                lat_lvl = i_master_dma ? rd_lvl : wr_lvl;
                drv_lvl = i_master_dma ? wr_lvl : rd_lvl;
            end
            MAP_ACK1: begin
                lat_lvl = i_master_dma ? rd_lvl : ack_lvl;
                drv_lvl = i_master_dma ? ack_lvl : rd_lvl;
            end
            MAP_ACK: begin
                lat_lvl = ack_lvl;
                drv_lvl = ack_lvl;
            end
            default: begin
                lat_lvl = 1'b0;
                drv_lvl = 1'b0;
            end
        endcase
    end

    // Transfer size and counter enable
    assign cnt_en = i_master_dma | ~st_r.dis;
    assign two = st_r.w16 | i_pio;
    assign step = two ? 4'h2 : 4'h1;
    assign room = FIFO_BYTES - st_r.fcnt;
    assign lat_edge = lat_lvl & ~st_r.lat_q;
    assign drv_edge = drv_lvl & ~st_r.drv_q;

    // Next-state logic
    always_comb begin
        logic [3:0] push;
        logic [3:0] pop;
        logic moved;
        push = 4'h0;
        pop = 4'h0;
        moved = 1'b0;
        st_nxt = st_r;
        st_nxt.lat_q = lat_lvl;
        st_nxt.drv_q = drv_lvl;
        st_nxt.rel = 1'b0;
        st_nxt.rdata = 32'h0000_0000;
        // Register reads answer next cycle, unmapped reads zero
        if (i_rd && i_addr == ADDR_COUNT) begin
            st_nxt.rdata = st_r.count;
        end else if (i_rd && i_addr == ADDR_CFG) begin
            st_nxt.rdata[CFG_CORE] = st_r.core;
            st_nxt.rdata[CFG_TIM_LO +: 2] = st_r.tim;
            st_nxt.rdata[CFG_PIO_LO +: 3] = st_r.pio;
            st_nxt.rdata[CFG_DIS] = st_r.dis;
            st_nxt.rdata[CFG_MAP_LO +: 2] = st_r.map;
            st_nxt.rdata[CFG_WIDTH] = st_r.w16;
        end
        // IN: bus data into FIFO; both bytes must fit or the strobe is dropped
        if (st_r.active && st_r.dir_in && lat_edge && room >= step) begin
            st_nxt.fifo[st_r.wp] = i_dma_data[7:0];
            if (two) begin
                st_nxt.fifo[st_r.wp + 3'h1] = i_dma_data[15:8];
            end
            push = step;
            moved = 1'b1;
        end
        // OUT: endpoint bytes into FIFO
        if (o_ep_rd_ready && i_ep_rd_valid) begin
            st_nxt.fifo[st_r.wp] = i_ep_rd_data;
            push = 4'h1;
        end
        // IN: FIFO to endpoint one byte per cycle, so 8 bytes take 80 ns at a 10 ns clock
        if (st_r.ep_vld && i_ep_wr_ready) begin
            st_nxt.ep_vld = 1'b0;
        end
        if (st_r.dir_in && st_r.fcnt != 4'h0 && (!st_r.ep_vld || i_ep_wr_ready)) begin
            st_nxt.ep_data = st_r.fifo[st_r.rp];
            st_nxt.ep_vld = 1'b1;
            pop = 4'h1;
        end
        // OUT: FIFO onto the bus on the drive strobe
        if (st_r.active && !st_r.dir_in && drv_edge && st_r.fcnt >= step) begin
            st_nxt.dout = {two ? st_r.fifo[st_r.rp + 3'h1] : 8'h00, st_r.fifo[st_r.rp]};
            pop = step;
            moved = 1'b1;
        end
        st_nxt.wp = st_r.wp + push[2:0];
        st_nxt.rp = st_r.rp + pop[2:0];
        st_nxt.fcnt = st_r.fcnt + push - pop;
        // Count down; disabled counter wraps and never ends the transfer
        if (moved) begin
            st_nxt.count = st_r.count - {28'h0000_000, step};
            if (cnt_en && st_r.count <= {28'h0000_000, step}) begin
                st_nxt.count = 32'h0000_0000;
                st_nxt.active = 1'b0;
                st_nxt.pend_rel = ~st_r.dir_in;
            end
        end
        if (i_xfer_stop && st_r.active) begin
            st_nxt.active = 1'b0;
            st_nxt.pend_rel = ~st_r.dir_in;
        end
        if (i_xfer_start) begin
            st_nxt.active = 1'b1;
            st_nxt.dir_in = i_dir_in;
            st_nxt.pend_rel = 1'b0;
        end
        // Buffer released only once the FIFO has been read out
        if (st_r.pend_rel && st_r.fcnt == 4'h0) begin
            st_nxt.rel = 1'b1;
            st_nxt.pend_rel = 1'b0;
        end
        // Register writes take priority over hardware count-down
        if (i_wr && i_addr == ADDR_COUNT) begin
            st_nxt.count = i_wdata;
        end
        if (i_wr && i_addr == ADDR_CFG) begin
            st_nxt.core = i_wdata[CFG_CORE];
            st_nxt.tim = i_wdata[CFG_TIM_LO +: 2];
            st_nxt.pio = i_wdata[CFG_PIO_LO +: 3];
            st_nxt.dis = i_wdata[CFG_DIS];
            st_nxt.map = i_wdata[CFG_MAP_LO +: 2];
            st_nxt.w16 = i_wdata[CFG_WIDTH];
            st_nxt.cfg_seen = 1'b1;
        end
    end

    // State register
    always_ff @(posedge i_mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            st_r <= '0;
            st_r.count <= COUNT_RST;
            st_r.core <= CFG_RST[CFG_CORE];
            st_r.tim <= CFG_RST[CFG_TIM_LO +: 2];
            st_r.pio <= CFG_RST[CFG_PIO_LO +: 3];
            st_r.dis <= CFG_RST[CFG_DIS];
            st_r.map <= CFG_RST[CFG_MAP_LO +: 2];
            st_r.w16 <= CFG_RST[CFG_WIDTH];
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs
    assign o_rdata = st_r.rdata;
    assign o_dma_data = st_r.dout;
    assign o_dma_data_oe = st_r.active & ~st_r.dir_in;
    assign o_ep_wr_data = st_r.ep_data;
    assign o_ep_wr_valid = st_r.ep_vld;
    // Prefetch stops at the count unless the counter is disabled, so the FIFO is empty when the count runs out
    assign o_ep_rd_ready = st_r.active & ~st_r.dir_in & (st_r.fcnt < FIFO_BYTES) &
        (~cnt_en | ({28'h0000_000, st_r.fcnt} < st_r.count));
    assign o_ep_release = st_r.rel;
    // Request waits for a configuration write and FIFO space or data
    assign o_dma_request = st_r.cfg_seen & st_r.active &
        (st_r.dir_in ? room >= step : st_r.fcnt >= step);
    assign o_core_mode_select = st_r.core;
    assign o_master_timing = st_r.tim;
    assign o_strobe_timing_en = i_master_dma & (st_r.tim == TIM_CUSTOM);
    assign o_pio_timing_select = st_r.pio;
    assign o_bus_16 = st_r.w16;

    // Checks
    property p_req_needs_cfg;
        @(posedge i_mclk) disable iff (!rst_sync_b) $rose(st_r.cfg_seen) |-> $past(i_wr) && $past(i_addr) == ADDR_CFG;
    endproperty
    a_req_needs_cfg: assert property (p_req_needs_cfg) else $error("request before config write");
    property p_fifo_cap;
        @(posedge i_mclk) disable iff (!rst_sync_b) st_r.fcnt <= FIFO_BYTES;
    endproperty
    a_fifo_cap: assert property (p_fifo_cap) else $error("fifo over 8 bytes");
    property p_drain;
        @(posedge i_mclk) disable iff (!rst_sync_b)
        (st_r.dir_in && st_r.fcnt != 4'h0 && !st_r.ep_vld) |=> o_ep_wr_valid;
    endproperty
    a_drain: assert property (p_drain) else $error("fifo byte not offered");
    property p_release;
        @(posedge i_mclk) disable iff (!rst_sync_b) o_ep_release |-> $past(st_r.fcnt) == 4'h0;
    endproperty
    a_release: assert property (p_release) else $error("release with fifo data");
    property p_dec;
        @(posedge i_mclk) disable iff (!rst_sync_b)
        (st_r.active && st_r.dir_in && lat_edge && room >= step && !i_wr && step == 4'h2 &&
         st_r.count > 32'h0000_0002) |=> st_r.count == $past(st_r.count) - 32'h0000_0002;
    endproperty
    a_dec: assert property (p_dec) else $error("count not down by two");
    property p_wrap;
        @(posedge i_mclk) disable iff (!rst_sync_b)
        (!cnt_en && st_r.active && st_r.count < {28'h0000_000, step} && lat_edge && st_r.dir_in &&
         room >= step && !i_wr && !i_xfer_stop) |=> st_r.active && st_r.count[31];
    endproperty
    a_wrap: assert property (p_wrap) else $error("disabled counter did not wrap");
    property p_master_en;
        @(posedge i_mclk) disable iff (!rst_sync_b)
        (i_master_dma && st_r.dis && st_r.active && st_r.dir_in && lat_edge && room >= step && !i_wr &&
         !i_xfer_start && st_r.count <= {28'h0000_000, step}) |=> !st_r.active && st_r.count == 32'h0000_0000;
    endproperty
    a_master_en: assert property (p_master_en) else $error("counter disabled in master mode");
    property p_rd_count;
        @(posedge i_mclk) disable iff (!rst_sync_b) (i_rd && i_addr == ADDR_COUNT) |=> o_rdata == $past(st_r.count);
    endproperty
    a_rd_count: assert property (p_rd_count) else $error("count readback wrong");
    property p_map_rsv;
        @(posedge i_mclk) disable iff (!rst_sync_b)
        (st_r.map == 2'h3 && !i_wr) |-> (!lat_lvl && !drv_lvl) ##1 (st_r.count == $past(st_r.count));
    endproperty
    a_map_rsv: assert property (p_map_rsv) else $error("reserved map moved data");
    c_in_done: cover property (@(posedge i_mclk) disable iff (!rst_sync_b) $fell(st_r.active) && st_r.dir_in);
    c_out_rel: cover property (@(posedge i_mclk) disable iff (!rst_sync_b) o_ep_release);
    c_fifo_full: cover property (@(posedge i_mclk) disable iff (!rst_sync_b) st_r.fcnt == FIFO_BYTES);
endmodule : dma_counter_and_config
`default_nettype wire

// *** src/dma_cc_pkg.sv ***
package dma_cc_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_COUNT = 8'h34;
    localparam logic [7:0] ADDR_CFG = 8'h38;
    // Configuration field positions
    localparam int CFG_CORE = 13;
    localparam int CFG_TIM_LO = 11;
    localparam int CFG_PIO_LO = 8;
    localparam int CFG_DIS = 7;
    localparam int CFG_MAP_LO = 2;
    localparam int CFG_WIDTH = 0;
    // Values after reset
    localparam logic [31:0] COUNT_RST = 32'h0000_0000;
    localparam logic [15:0] CFG_RST = 16'h0001;
    // Strobe map codes and the custom timing code
    localparam logic [1:0] MAP_RW = 2'h0;
    localparam logic [1:0] MAP_ACK1 = 2'h1;
    localparam logic [1:0] MAP_ACK = 2'h2;
    localparam logic [1:0] TIM_CUSTOM = 2'h3;
    // FIFO size in bytes and hand-off time
    localparam logic [3:0] FIFO_BYTES = 4'h8;
    localparam int CLK_NS = 10;
    localparam int EP_DELAY_NS = 60;
    localparam int EP_DELAY_CYC = (EP_DELAY_NS / CLK_NS < 1) ? 1 : EP_DELAY_NS / CLK_NS;
endpackage : dma_cc_pkg

// *** src/pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_b,
    // Pin and filtered level
    input wire logic i_pin,
    output logic o_level
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic lvl_r;

    // Third stage lets a change count only once two stages agree
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            lvl_r <= 1'b0;
        end else begin
            s1_r <= i_pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                lvl_r <= s3_r;
            end
        end
    end

    assign o_level = lvl_r;
endmodule : pin_sync
`default_nettype wire

// *** dv/dma_far_end.sv ***
`timescale 1ns/1ps
`default_nettype none
module dma_far_end (
    // Clock and command from the bench
    input wire logic i_mclk,
    input wire logic i_kick,
    input wire logic [1:0] i_sel,
    input wire logic [15:0] i_word,
    // Handshake pins toward the block
    output logic o_read_strobe,
    output logic o_write_strobe,
    output logic o_acknowledge,
    output logic [15:0] o_data,
    output logic o_busy
);
    // One strobe: 6 cycles high, 7 low, so the 3-flop sync sees both levels
    initial begin
        o_read_strobe = 1'b0;
        o_write_strobe = 1'b0;
        o_acknowledge = 1'b0;
        o_data = 16'h0000;
        o_busy = 1'b0;
        forever begin
            @(posedge i_mclk);
            if (i_kick) begin
                o_busy <= 1'b1;
                o_data <= i_word;
                repeat (2) @(posedge i_mclk);
                o_read_strobe <= (i_sel == 2'h0);
                o_write_strobe <= (i_sel == 2'h1);
                o_acknowledge <= (i_sel == 2'h2);
                repeat (6) @(posedge i_mclk);
                {o_read_strobe, o_write_strobe, o_acknowledge} <= 3'h0;
                @(posedge i_mclk);
                // Released bus: no stale value left behind
                o_data <= ~i_word;
                repeat (6) @(posedge i_mclk);
                o_busy <= 1'b0;
            end
        end
    end
endmodule : dma_far_end
`default_nettype wire

// *** dv/tb_dma_counter_and_config.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_dma_counter_and_config;
    import dma_cc_pkg::*;
    typedef struct packed {
        logic m;
        logic [1:0] map;
        logic w;
        logic p;
        logic [1:0] good;
        logic [1:0] bad;
        logic [31:0] step;
    } row_t;
    logic mclk, rst_b, wr, rd, master, start, stop, pio, rs, ws, ack, req, core, ste, b16, kick, busy;
    logic dir, ep_v, ep_rdy, ep_wv, rel, oe;
    logic [7:0] epb = 8'h10;
    logic [7:0] ep_wd;
    logic [15:0] dout;
    logic [15:0] ep_last = 16'h0000;
    int n_rel = 0;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, got;
    logic [15:0] bus_in, word;
    logic [1:0] tim, sel;
    logic [2:0] piot;
    int n_fail = 0;
    int tests_run = 0;
    // Sel codes: 0 read strobe, 1 write strobe, 2 acknowledge
    row_t rows [7] = '{
        '{1'b0, MAP_RW, 1'b1, 1'b0, 2'h1, 2'h0, 32'h2},
        '{1'b1, MAP_RW, 1'b0, 1'b0, 2'h0, 2'h1, 32'h1},
        '{1'b0, MAP_ACK1, 1'b1, 1'b0, 2'h2, 2'h1, 32'h2},
        '{1'b1, MAP_ACK1, 1'b0, 1'b0, 2'h0, 2'h2, 32'h1},
        '{1'b0, MAP_ACK, 1'b1, 1'b0, 2'h2, 2'h1, 32'h2},
        '{1'b1, MAP_ACK, 1'b1, 1'b0, 2'h2, 2'h0, 32'h2},
        '{1'b0, MAP_RW, 1'b0, 1'b1, 2'h1, 2'h0, 32'h2}
    };
    dma_counter_and_config u_dut (
        .i_mclk(mclk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .i_master_dma(master), .i_xfer_start(start), .i_xfer_stop(stop),
        .i_dir_in(dir), .i_pio(pio), .i_dma_read_strobe(rs), .i_dma_write_strobe(ws),
        .i_dma_acknowledge(ack), .i_dma_data(bus_in), .o_dma_data(dout), .o_dma_data_oe(oe),
        .o_dma_request(req), .o_ep_wr_data(ep_wd), .o_ep_wr_valid(ep_wv), .i_ep_wr_ready(1'b1),
        .i_ep_rd_data(epb), .i_ep_rd_valid(ep_v), .o_ep_rd_ready(ep_rdy), .o_ep_release(rel),
        .o_core_mode_select(core), .o_master_timing(tim), .o_strobe_timing_en(ste),
        .o_pio_timing_select(piot), .o_bus_16(b16)
    );
    dma_far_end u_far (
        .i_mclk(mclk), .i_kick(kick), .i_sel(sel), .i_word(word), .o_read_strobe(rs),
        .o_write_strobe(ws), .o_acknowledge(ack), .o_data(bus_in), .o_busy(busy)
    );
    // Clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Endpoint side: last bytes handed over, release pulses counted, OUT bytes numbered
    always @(posedge mclk) begin
        if (ep_wv) ep_last <= {ep_last[7:0], ep_wd};
        if (ep_rdy && ep_v) epb <= epb + 8'h01;
        if (rel) n_rel <= n_rel + 1;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wr_reg
    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    task automatic pulse(input logic is_stop);
        @(posedge mclk);
        if (is_stop) stop <= 1'b1;
        else start <= 1'b1;
        @(posedge mclk);
        {start, stop} <= 2'h0;
        repeat (2) @(posedge mclk);
    endtask : pulse
    // Bounded wait: partner busy spans about 15 cycles
    task automatic strobe(input logic [1:0] s);
        @(posedge mclk);
        kick <= 1'b1;
        sel <= s;
        word <= 16'ha5c3;
        @(posedge mclk);
        kick <= 1'b0;
        for (int i = 0; i < 40; i++) begin
            @(posedge mclk);
            if (!busy) break;
        end
        repeat (4) @(posedge mclk);
    endtask : strobe
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : conclude
    // Hang guard, far above the expected run length
    initial begin
        #100us;
        n_fail++;
        conclude();
    end
    initial begin
        {rst_b, wr, rd, master, start, stop, pio, kick} = 8'h00;
        addr = 8'h00;
        wdata = 32'h0;
        sel = 2'h0;
        word = 16'h0000;
        dir = 1'b1;
        ep_v = 1'b0;
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (3) @(posedge mclk);
        rd_reg(ADDR_COUNT, got); chk(got, 32'h0);
        rd_reg(ADDR_CFG, got); chk(got, 32'h1);
        chk({31'h0, b16}, 32'h1);
        pulse(1'b0); chk({31'h0, req}, 32'h0);
        pulse(1'b1);
        $display("reset test done");
        master <= 1'b1;
        wr_reg(ADDR_CFG, 32'hffff_ffff);
        rd_reg(ADDR_CFG, got); chk(got, 32'h3f8d);
        chk({core, tim, ste, piot}, 32'h7f);
        master <= 1'b0;
        @(posedge mclk);
        #1 chk({31'h0, ste}, 32'h0);
        rd_reg(8'h3c, got); chk(got, 32'h0);
        wr_reg(ADDR_COUNT, 32'h1234_5678);
        rd_reg(ADDR_COUNT, got); chk(got, 32'h1234_5678);
        $display("register test done");
        foreach (rows[i]) begin
            master <= rows[i].m;
            pio <= rows[i].p;
            wr_reg(ADDR_CFG, {28'h0, rows[i].map, 1'b0, rows[i].w});
            wr_reg(ADDR_COUNT, 32'h40);
            pulse(1'b0); chk({31'h0, req}, 32'h1);
            strobe(rows[i].bad);
            strobe(rows[i].good);
            rd_reg(ADDR_COUNT, got); chk(got, 32'h40 - rows[i].step);
            chk({24'h0, ep_last[7:0]}, (rows[i].step == 32'h2) ? 32'ha5 : 32'hc3);
            pulse(1'b1);
            $display("row %0d done", i);
        end
        pio <= 1'b0;
        master <= 1'b0;
        wr_reg(ADDR_CFG, 32'h81);
        wr_reg(ADDR_COUNT, 32'h1);
        pulse(1'b0);
        strobe(2'h1);
        rd_reg(ADDR_COUNT, got); chk(got, 32'hffff_ffff);
        chk({31'h0, req}, 32'h1);
        pulse(1'b1);
        $display("wrap test done");
        master <= 1'b1;
        wr_reg(ADDR_CFG, 32'h80);
        wr_reg(ADDR_COUNT, 32'h1);
        pulse(1'b0);
        strobe(2'h0);
        rd_reg(ADDR_COUNT, got); chk(got, 32'h0);
        chk({31'h0, req}, 32'h0);
        pulse(1'b1);
        $display("master enable test done");
        master <= 1'b0;
        wr_reg(ADDR_CFG, 32'hd);
        wr_reg(ADDR_COUNT, 32'h40);
        pulse(1'b0);
        strobe(2'h1);
        rd_reg(ADDR_COUNT, got); chk(got, 32'h40);
        pulse(1'b1);
        $display("reserved map test done");
        dir <= 1'b0;
        ep_v <= 1'b1;
        wr_reg(ADDR_CFG, 32'h1);
        wr_reg(ADDR_COUNT, 32'h2);
        pulse(1'b0); chk({31'h0, oe}, 32'h1);
        strobe(2'h0);
        chk({16'h0, dout}, 32'h1110);
        chk(n_rel, 32'h1);
        rd_reg(ADDR_COUNT, got); chk(got, 32'h0);
        chk({30'h0, oe, req}, 32'h0);
        $display("out test done");
        conclude();
    end
endmodule : tb_dma_counter_and_config
`default_nettype wire
